// file: core/sfp_map.svh
/*
  constants for the 18-bit synchronous fifo with programmable flags.
  assumes nothing beyond being included once, by the package; the core uses its macros without including it.
*/
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
`define SFP_WORD_W        18
`define SFP_OFS_W         12
`define SFP_DEPTH_DEF     64
`define SFP_OFS_MIN_DEPTH 64
`define SFP_DEF_OFS_64    12'h007
`define SFP_DEF_OFS_256   12'h01f
`define SFP_DEF_OFS_512   12'h03f
`define SFP_DEF_OFS_BIG   12'h07f
`define SFP_CLK_PERIOD_NS 50
`endif

// file: core/sfp_pkg.sv
/*
  types for the synchronous fifo core.
  assumes sfp_map.svh is on the include path.
*/
`include "sfp_map.svh"
package sfp_pkg;
    typedef logic [`SFP_WORD_W-1:0] sfp_word_t;
    typedef enum logic {SFP_SEL_EMPTY_OFS = 1'b0, SFP_SEL_FULL_OFS = 1'b1} sfp_sel_e;
    typedef struct packed {
        logic full_flag_n;
        logic almost_full_n;
        logic half_flag_n;
        logic almost_empty_n;
        logic empty_flag_n;
    } sfp_flags_s;
endpackage

// file: core/sfp_fifo.sv
/*
  single-clock model of the 18-bit fifo with programmable almost flags.
  assumes read and write clocks are tied to mclk and all inputs are synchronous to it.
*/
// What this block does
// (R1) reset empties fifo, clears both pointers, empty flag low.
// (R2) after reset outputs low with output enable low, released otherwise.
// (R3) outside party gives no read or write while reset held.
// (R4) write enable low, load high: store push word each edge.
// (R5) read enable low: present next word each edge, advance read pointer.
// (R6) output enable high releases outputs, low drives output register.
// (R7) cascaded: only the read-enabled device drives shared outputs; here output enable alone sets pop_word_oe.
// (R8) writes ignored while full flag low; here up to two are still taken into the skid buffer.
// (R9) reads ignored while empty flag low, pointer holds.
// (R10) empty fifo keeps last read word on outputs.
// (R11) full flag low when full, changes on write edge only.
// (R12) empty flag low when empty, changes on read edge only.
// (R13) empty/full synchronous; almost flags synchronous only with sync select low.
// (R14) full flag may release one write edge late on tight skew.
// (R15) empty flag may release one read edge late on tight skew.
// (R16) first word available cycle after empty flag goes high.
// (R17) two 12-bit offset registers loaded from push word bits 0-11.
// (R18) load and write low: empty offset, full offset, empty offset again.
// (R19) load/write decode: 00 program, 01 nop, 10 write fifo, 11 nop.
// (R20) load and read low: offset registers read out in same sequence.
// (R21) unprogrammed offsets use built-in defaults.
// (R22) storage is an 18-bit array of 64 to 4K words.
// (R23) almost empty at count<=n, almost full at count>=depth-m, half above half.
// (R24) default offset 7, 31, 63 or 127 by depth.
// (R25) pointers wrap after last location.
`timescale 1ns/1ns
module sfp_fifo
    import sfp_pkg::*;
#(
    parameter int DEPTH = `SFP_DEPTH_DEF
)(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       master_clear_n,
    input  wire logic       write_en_n,
    input  wire logic       read_en_n,
    input  wire logic       output_en_n,
    input  wire logic       offset_load_n,
    input  wire logic       flag_sync_select_n,
    input  wire sfp_word_t  push_word,
    output logic            push_ready,
    output sfp_word_t       pop_word,
    output logic [17:0]     pop_word_oe,
    output sfp_flags_s      flags
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [11:0] DEF_OFS = (DEPTH <= 64)  ? `SFP_DEF_OFS_64  :
                                      (DEPTH <= 256) ? `SFP_DEF_OFS_256 :
                                      (DEPTH <= 512) ? `SFP_DEF_OFS_512 : `SFP_DEF_OFS_BIG; // R24
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW:0] HALF_C  = (AW+1)'(DEPTH/2);

    sfp_word_t          mem [DEPTH];                       // R22
    logic [AW-1:0]      wr_ptr;
    logic [AW-1:0]      rd_ptr;
    logic [AW:0]        count;
    logic [11:0]        almost_empty_distance;
    logic [11:0]        almost_full_distance;
    sfp_sel_e           wr_sel;
    sfp_sel_e           rd_sel;
    logic               clear_q;

    // two-entry skid buffer on the write path: a word offered while both entries are in use is not taken
    sfp_word_t          skid [2];
    logic [1:0]         skid_cnt;
    logic               skid_head;

    wire clr_now   = reset | ~master_clear_n;              // R1
    wire prog_wr   = ~offset_load_n & ~write_en_n;         // R19
    wire fifo_wr   = offset_load_n & ~write_en_n;          // R19
    wire prog_rd   = ~offset_load_n & ~read_en_n;          // R20
    wire is_full   = (count == DEPTH_C);
    wire is_empty  = (count == '0);
    wire in_take   = fifo_wr & (skid_cnt != 2'd2);         // R4
    wire skid_vld  = (skid_cnt != 2'd0);
    wire mem_wr    = skid_vld & ~is_full;                  // R8
    wire mem_rd    = offset_load_n & ~read_en_n & ~is_empty; // R9
    logic [AW-1:0]      wr_ptr_inc;
    logic [AW-1:0]      rd_ptr_inc;
    sfp_ptr_step #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) wr_step_u (
        .cur (wr_ptr),
        .nxt (wr_ptr_inc)
    );
    sfp_ptr_step #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) rd_step_u (
        .cur (rd_ptr),
        .nxt (rd_ptr_inc)
    );
    wire [AW:0] next_count = count + (AW+1)'(mem_wr) - (AW+1)'(mem_rd);
    wire [AW:0] ae_lim  = (AW+1)'(almost_empty_distance);
    wire [AW:0] af_lim  = DEPTH_C - (AW+1)'(almost_full_distance);
    wire ae_now = (next_count <= ae_lim);                  // R23
    wire af_now = (next_count >= af_lim);                  // R23
    wire ae_cur = (count <= ae_lim);
    wire af_cur = (count >= af_lim);
    wire [1:0] skid_push = {1'b0, in_take};
    wire [1:0] skid_pop  = {1'b0, mem_wr};

    always_ff @(posedge mclk)
    begin
        if (in_take)
            skid[skid_head ^ skid_cnt[0]] <= push_word;
        if (mem_wr)
            mem[wr_ptr] <= skid[skid_head];                // R4
    end

    always_ff @(posedge mclk)
    begin
        if (clr_now)
        begin
            skid_cnt  <= 2'd0;
            skid_head <= 1'b0;
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
        end
        else
        begin
            skid_cnt  <= skid_cnt + skid_push - skid_pop;
            skid_head <= skid_head ^ mem_wr;
            count     <= next_count;
            if (mem_wr)
                wr_ptr <= wr_ptr_inc;
            if (mem_rd)
                rd_ptr <= rd_ptr_inc;                      // R5
        end
    end

    // offset registers keep their values over a master clear, defaults only at reset
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            almost_empty_distance <= DEF_OFS;              // R21
            almost_full_distance  <= DEF_OFS;              // R21
            wr_sel                <= SFP_SEL_EMPTY_OFS;
            rd_sel                <= SFP_SEL_EMPTY_OFS;
        end
        else
        begin
            if (prog_wr)                                   // R18
            begin
                if (wr_sel == SFP_SEL_EMPTY_OFS)
                    almost_empty_distance <= push_word[11:0]; // R17
                else
                    almost_full_distance  <= push_word[11:0]; // R17
                wr_sel <= sfp_sel_e'(~wr_sel);
            end
            if (prog_rd)
                rd_sel <= sfp_sel_e'(~rd_sel);             // R20
        end
    end

    wire [17:0] ofs_word = {6'h00, (rd_sel == SFP_SEL_EMPTY_OFS) ? almost_empty_distance : almost_full_distance};

    always_ff @(posedge mclk)
    begin
        clear_q <= clr_now;
        if (clr_now)
            pop_word <= '0;                                // R2
        else if (mem_rd)
            pop_word <= mem[rd_ptr];                       // R5 R16
        else if (prog_rd)
            pop_word <= ofs_word;                          // R20
        // otherwise held, so an empty fifo keeps the last word  R10
    end

    // driven only when output enable is low; in a cascade the reader steers output enable  R7
    always_ff @(posedge mclk)
    begin
        if (reset)
            pop_word_oe <= '0;
        else
            pop_word_oe <= {18{~output_en_n}};             // R6 R2
    end

    always_ff @(posedge mclk)
    begin
        if (clr_now)
        begin
            flags       <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0}; // R1
            push_ready  <= 1'b0;
        end
        else
        begin
            // single clock domain: no skew, so flags never release late  R14 R15
            flags.full_flag_n    <= ~(next_count == DEPTH_C); // R11
            flags.empty_flag_n   <= ~(next_count == '0);      // R12
            flags.half_flag_n    <= ~(next_count > HALF_C);   // R23
            flags.almost_empty_n <= flag_sync_select_n ? ~ae_cur : ~ae_now; // R13
            flags.almost_full_n  <= flag_sync_select_n ? ~af_cur : ~af_now; // R13
            push_ready           <= (skid_cnt + skid_push - skid_pop) != 2'd2;
        end
    end

    a_write_blocked_full: assert property (@(posedge mclk) disable iff (clr_now) // R8
        is_full |-> !mem_wr) else $error("write accepted while full");
    a_read_blocked_empty: assert property (@(posedge mclk) disable iff (clr_now) // R9
        (is_empty && !mem_wr) |=> $stable(rd_ptr)) else $error("read pointer moved while empty");
    a_empty_flag_track: assert property (@(posedge mclk) disable iff (clr_now) // R12
        (count == '0) |-> !flags.empty_flag_n) else $error("empty flag high with zero count");
    a_full_flag_track: assert property (@(posedge mclk) disable iff (clr_now) // R11
        (count == DEPTH_C) |-> !flags.full_flag_n) else $error("full flag high at depth");
    a_reset_clears: assert property (@(posedge mclk) // R1
        clr_now |=> (count == '0 && !flags.empty_flag_n && wr_ptr == '0)) else $error("clear did not empty");
    a_hold_last_word: assert property (@(posedge mclk) disable iff (clr_now) // R10
        (is_empty && offset_load_n && !clear_q) |=> $stable(pop_word)) else $error("output changed when empty");
    a_oe_follows: assert property (@(posedge mclk) disable iff (reset) // R6
        output_en_n |=> (pop_word_oe == '0)) else $error("outputs driven with enable high");
    a_prog_sequence: assert property (@(posedge mclk) disable iff (reset) // R18
        (prog_wr && wr_sel == SFP_SEL_EMPTY_OFS) |=> almost_empty_distance == $past(push_word[11:0]))
        else $error("empty offset not loaded first");
    a_ptr_wrap: assert property (@(posedge mclk) disable iff (clr_now) // R25
        (mem_rd && rd_ptr == AW'(DEPTH-1)) |=> rd_ptr == '0) else $error("read pointer did not wrap");

    // occupancy, pointers and data path
    a_count_bound: assert property (@(posedge mclk) disable iff (clr_now) // R22
        count <= DEPTH_C)
        else $error("count above depth");

    a_count_idle: assert property (@(posedge mclk) disable iff (clr_now) // R4 R5
        (!mem_wr && !mem_rd) |=> $stable(count))
        else $error("count moved without transfer");

    a_count_up: assert property (@(posedge mclk) disable iff (clr_now) // R4
        (mem_wr && !mem_rd) |=> count == $past(count) + (AW+1)'(1))
        else $error("count did not rise on write");

    a_count_down: assert property (@(posedge mclk) disable iff (clr_now) // R5
        (mem_rd && !mem_wr) |=> count == $past(count) - (AW+1)'(1))
        else $error("count did not fall on read");

    a_wr_ptr_hold: assert property (@(posedge mclk) disable iff (clr_now) // R8
        !mem_wr |=> $stable(wr_ptr))
        else $error("write pointer moved without write");

    a_wr_ptr_wrap: assert property (@(posedge mclk) disable iff (clr_now) // R25
        (mem_wr && wr_ptr == AW'(DEPTH-1)) |=> wr_ptr == '0)
        else $error("write pointer did not wrap");

    a_rd_ptr_step: assert property (@(posedge mclk) disable iff (clr_now) // R5 R25
        mem_rd |=> rd_ptr == $past(rd_ptr_inc))
        else $error("read pointer did not step");

    a_pop_from_mem: assert property (@(posedge mclk) disable iff (clr_now) // R5 R16
        mem_rd |=> pop_word == mem[$past(rd_ptr)])
        else $error("read word not from head location");

    // flags against the occupancy they describe
    a_empty_flag_off: assert property (@(posedge mclk) disable iff (clr_now) // R12
        (count != '0) |-> flags.empty_flag_n)
        else $error("empty flag low with data stored");

    a_full_flag_off: assert property (@(posedge mclk) disable iff (clr_now) // R11
        (count != DEPTH_C) |-> flags.full_flag_n)
        else $error("full flag low below depth");

    a_half_flag_level: assert property (@(posedge mclk) disable iff (clr_now) // R23
        flags.half_flag_n == (count <= HALF_C))
        else $error("half flag disagrees with count");

    a_ae_sync_mode: assert property (@(posedge mclk) disable iff (clr_now) // R13 R23
        (!clear_q && !$past(flag_sync_select_n) && !$past(prog_wr)) |-> flags.almost_empty_n == !ae_cur)
        else $error("almost empty wrong in sync mode");

    a_af_sync_mode: assert property (@(posedge mclk) disable iff (clr_now) // R13 R23
        (!clear_q && !$past(flag_sync_select_n) && !$past(prog_wr)) |-> flags.almost_full_n == !af_cur)
        else $error("almost full wrong in sync mode");

    a_ae_lag_mode: assert property (@(posedge mclk) disable iff (clr_now) // R13
        (!clear_q && $past(flag_sync_select_n)) |-> flags.almost_empty_n == !$past(ae_cur))
        else $error("almost empty wrong in lagged mode");

    a_af_lag_mode: assert property (@(posedge mclk) disable iff (clr_now) // R13
        (!clear_q && $past(flag_sync_select_n)) |-> flags.almost_full_n == !$past(af_cur))
        else $error("almost full wrong in lagged mode");

    // offset registers, write decode, input buffer, output enable and clear
    a_offset_full_load: assert property (@(posedge mclk) disable iff (reset) // R17 R18
        (prog_wr && wr_sel == SFP_SEL_FULL_OFS) |=> almost_full_distance == $past(push_word[11:0]))
        else $error("full offset not loaded second");

    a_offset_sel_step: assert property (@(posedge mclk) disable iff (reset) // R18
        prog_wr |=> wr_sel != $past(wr_sel))
        else $error("offset write select did not advance");

    a_offset_keep: assert property (@(posedge mclk) disable iff (reset) // R19
        !prog_wr |=> ($stable(almost_empty_distance) && $stable(almost_full_distance)))
        else $error("offset changed without program write");

    a_offset_readout: assert property (@(posedge mclk) disable iff (clr_now) // R20
        prog_rd |=> pop_word == $past(ofs_word))
        else $error("offset readout wrong");

    a_read_sel_step: assert property (@(posedge mclk) disable iff (reset) // R20
        prog_rd |=> rd_sel != $past(rd_sel))
        else $error("offset read select did not advance");

    a_nop_no_take: assert property (@(posedge mclk) disable iff (clr_now) // R19
        !fifo_wr |-> !in_take)
        else $error("word taken outside fifo write decode");

    a_ready_room: assert property (@(posedge mclk) disable iff (clr_now) // R4
        push_ready |-> (skid_cnt != 2'd2))
        else $error("ready shown with buffer full");

    a_skid_bound: assert property (@(posedge mclk) disable iff (clr_now) // R4
        skid_cnt != 2'd3)
        else $error("input buffer overfilled");

    a_oe_drive: assert property (@(posedge mclk) disable iff (reset) // R6 R2
        !output_en_n |=> pop_word_oe == '1)
        else $error("outputs released with enable low");

    a_defaults_load: assert property (@(posedge mclk) // R21 R24
        reset |=> (almost_empty_distance == DEF_OFS && almost_full_distance == DEF_OFS))
        else $error("offset defaults not loaded");

    a_pop_cleared: assert property (@(posedge mclk) // R2
        clr_now |=> pop_word == '0)
        else $error("output word not cleared");

    a_clear_keeps_ofs: assert property (@(posedge mclk) // R1
        (!master_clear_n && !reset && !prog_wr) |=> $stable(almost_empty_distance))
        else $error("master clear disturbed offset");

endmodule // sfp_fifo

module sfp_ptr_step
#(
    parameter int DEPTH = `SFP_DEPTH_DEF,
    parameter int AW    = $clog2(DEPTH)
)(
    input  wire logic [AW-1:0] cur,
    output logic [AW-1:0]      nxt
);
    // explicit wrap keeps a depth that is not a power of two inside the array
    wire at_last = (cur == AW'(DEPTH-1));
    assign nxt = at_last ? '0 : cur + 1'b1; // R25
endmodule // sfp_ptr_step

// file: sim/sfp_reader_model.sv
/* reader model for the pop side: one read, then a pause, while go is high.
   assumes flags and pop_word come from sfp_fifo on the same mclk. */
`timescale 1ns/1ns
module sfp_reader_model
    import sfp_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      go,
    input  wire logic      empty_flag_n,
    input  wire sfp_word_t pop_word,
    output logic           read_en_n = 1'b1,
    output logic           got = 1'b0,
    output sfp_word_t      word
);
    logic [2:0] step = 3'h0;
    // the pause lets the registered empty flag catch up before the next read
    always @(posedge mclk)
    begin
        got       <= (step == 3'h4);
        word      <= pop_word;
        read_en_n <= !(go && empty_flag_n && step == 3'h0);
        if (step != 3'h0 || (go && empty_flag_n))
            step <= step + 3'h1;
    end
endmodule // sfp_reader_model

// file: sim/tb.sv
/* bench for sfp_fifo: reset, order and thresholds, fill to full, offsets.
   assumes the reader model drains the pop side while go is high. */
`timescale 1ns/1ns
module tb
    import sfp_pkg::*;
;
    logic        mclk = 1'b0, reset = 1'b1, clr_n = 1'b1, wen_n = 1'b1, ren_n = 1'b1;
    logic        oe_n = 1'b0, ld_n = 1'b1, go = 1'b0, sync_n = 1'b0, push_ready, rd_n, got;
    sfp_word_t   din = 18'h00000, pop_word, word;
    logic [17:0] oe;
    sfp_flags_s  flags;
    int          n_mismatch = 0, checks_done = 0, cyc = 0, k;
    always #25 mclk = ~mclk;
    // the lagged almost-flag view runs during the order test, the synchronous one elsewhere
    sfp_fifo dut_u (.mclk(mclk), .reset(reset), .master_clear_n(clr_n), .write_en_n(wen_n),
        .read_en_n(rd_n & ren_n), .output_en_n(oe_n), .offset_load_n(ld_n), .flag_sync_select_n(sync_n),
        .push_word(din), .push_ready(push_ready), .pop_word(pop_word), .pop_word_oe(oe), .flags(flags));
    sfp_reader_model rdr_u (.mclk(mclk), .go(go), .empty_flag_n(flags.empty_flag_n),
        .pop_word(pop_word), .read_en_n(rd_n), .got(got), .word(word));
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp_word(string what, sfp_word_t exp, sfp_word_t seen);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmp_flags(sfp_flags_s exp);
        cmp_word("flags", 18'(exp), 18'(flags));
    endtask
    task automatic settle();
        repeat (4) @(negedge mclk);
    endtask
    // words offered while push_ready is low are held back, never lost
    task automatic write_n(sfp_word_t base, int n);
        k = 0;
        for (int t = 0; t < 200 && k < n; t++)
        begin
            @(negedge mclk);
            wen_n = !push_ready;
            din   = sfp_word_t'(base + k);
            k     = k + int'(push_ready);
        end
        @(negedge mclk);
        wen_n = 1'b1;
    endtask
    task automatic drain(sfp_word_t base, int n);
        int t;
        go = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            t = 0;
            do @(posedge mclk); while (got !== 1'b1 && ++t < 20);
            cmp_word("pop_word", sfp_word_t'(base + i), word);
        end
        @(negedge mclk);
        go = 1'b0;
    endtask
    task automatic t_reset();
        repeat (20) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        cmp_flags(5'h1c);
        cmp_word("pop_word", 18'h00000, pop_word);
        cmp_word("pop_word_oe", 18'h3ffff, oe);
        oe_n = 1'b1;
        @(negedge mclk);
        cmp_word("pop_word_oe", 18'h00000, oe);
        oe_n = 1'b0;
        $display("test reset done");
    endtask
    task automatic t_order();
        sync_n = 1'b1;
        write_n(18'h2a000, 7);
        settle();
        cmp_flags(5'h1d);
        write_n(18'h2a007, 1);
        settle();
        cmp_flags(5'h1f);
        drain(18'h2a000, 8);
        settle();
        ren_n = 1'b0;
        @(negedge mclk);
        ren_n = 1'b1;
        settle();
        cmp_word("pop_word", 18'h2a007, pop_word);
        cmp_flags(5'h1c);
        sync_n = 1'b0;
        $display("test order done");
    endtask
    task automatic t_fill();
        write_n(18'h15000, 100);
        settle();
        cmp_flags(5'h03);
        cmp_word("accepted", 18'h00001, 18'(k >= 64));
        drain(18'h15000, k);
        settle();
        cmp_flags(5'h1c);
        $display("test fill done");
    endtask
    task automatic t_offsets();
        sfp_word_t prog [3] = '{18'h3f005, 18'h3f009, 18'h3f003};
        ld_n  = 1'b0;
        wen_n = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            din = prog[i];
            @(negedge mclk);
        end
        wen_n = 1'b1;
        @(negedge mclk);
        ld_n  = 1'b1;
        @(negedge mclk);
        ld_n  = 1'b0;
        ren_n = 1'b0;
        @(negedge mclk);
        cmp_word("empty offset", 18'h00003, pop_word & 18'h00fff);
        @(negedge mclk);
        cmp_word("full offset", 18'h00009, pop_word & 18'h00fff);
        ren_n = 1'b1;
        ld_n  = 1'b1;
        settle();
        cmp_flags(5'h1c);
        write_n(18'h0c000, 3);
        settle();
        cmp_flags(5'h1d);
        write_n(18'h0c003, 1);
        settle();
        cmp_flags(5'h1f);
        clr_n = 1'b0;
        @(negedge mclk);
        clr_n = 1'b1;
        settle();
        cmp_flags(5'h1c);
        $display("test offsets done");
    endtask
    always @(posedge mclk)
        if (++cyc == 5000)
        begin
            n_mismatch++;
            summarize();
        end
    initial
    begin
        t_reset();
        t_order();
        t_fill();
        t_offsets();
        summarize();
    end
endmodule // tb
